// ### include/usm_pkg.sv
/*
 * Constants, register map and state type of the master-only SPI engine
 * built on a serial port. Assumes a 32-bit APB slave window with one
 * register per aligned word and an 8-bit data path inside.
 */
// Summary of operation
// - Receive-done flag is high exactly while the receive buffer holds unread bytes.
// - Transmit-done sets when frame ends with empty buffer; cleared by ack or write-one.
// - Buffer-empty flag shows free transmit buffer and is set after reset.
// - Receive-done interrupt needs its enable, global enable and the flag.
// - Transmit-done interrupt needs its enable, global enable and the flag.
// - Buffer-empty interrupt needs its enable, global enable and the flag.
// - Receiver enable takes the input pin; clearing it flushes the receive buffer.
// - With only the receiver enabled no transfer starts once pending transmit bytes have drained.
// - Transmitter enable takes the output pin as master data out.
// - Disabled transmitter finishes shift register and buffer before releasing the pin.
// - Mode field: 00 async, 01 sync, 10 reserved, 11 master SPI.
// - Order, phase and polarity are taken in the same write as mode.
// - Order bit one sends LSB first, zero MSB first, both directions.
// - Phase picks sampling on leading or trailing serial clock edge.
// - Polarity sets clock idle level; with phase fixes sample and setup edges.
// - Transmit path double buffered; receive path has one extra buffer level.
// - Master only: no slave select, no collision flag, no double speed.
// - Writing the data register starts a transfer once the shifter is free.
// - With a full receive buffer the newly arrived byte is dropped.
// - Frames are eight bits, back to back or with data line idling high.
// - Frame error, overrun and parity flags are not kept; the low status bits always read 5'h06.
package usm_pkg;
   // Register byte offsets
   localparam logic [11:0] USM_OFS_DATA = 12'h000;
   localparam logic [11:0] USM_OFS_STATUS = 12'h004;
   localparam logic [11:0] USM_OFS_ENABLE = 12'h008;
   localparam logic [11:0] USM_OFS_FORMAT = 12'h00C;
   localparam logic [11:0] USM_OFS_DIVISOR = 12'h010;
   localparam logic [11:0] USM_OFS_CPU = 12'h014;
   // Status bit positions
   localparam int USM_ST_RXC = 7;
   localparam int USM_ST_TXC = 6;
   localparam int USM_ST_UDRE = 5;
   // Enable control bit positions
   localparam int USM_EN_RXIE = 7;
   localparam int USM_EN_TXIE = 6;
   localparam int USM_EN_EMPTYIE = 5;
   localparam int USM_EN_RXEN = 4;
   localparam int USM_EN_TXEN = 3;
   // Format control bit positions
   localparam int USM_FMT_MODE_LO = 6;
   localparam int USM_FMT_ORDER = 2;
   localparam int USM_FMT_PHASE = 1;
   localparam int USM_FMT_POL = 0;
   localparam int USM_CPU_GIE = 0;
   // Reset values; low status bits read as their reset pattern
   localparam logic [4:0] USM_STATUS_LOW = 5'h06;
   localparam logic [7:0] USM_ENABLE_RST = 8'h00;
   localparam logic [7:0] USM_FORMAT_RST = 8'h00;
   localparam int USM_DIV_W = 12;
   // Mode field codes
   localparam logic [1:0] USM_MODE_ASYNC = 2'b00;
   localparam logic [1:0] USM_MODE_SYNC = 2'b01;
   localparam logic [1:0] USM_MODE_RSVD = 2'b10;
   localparam logic [1:0] USM_MODE_MSPI = 2'b11;
   // Frame shape: eight bits, two clock edges per bit
   localparam int USM_FRAME_BITS = 8;
   localparam logic [3:0] USM_LAST_EDGE = 4'hF;
   localparam int USM_RX_DEPTH = 2;
   typedef enum logic [1:0] {USM_IDLE = 2'b01, USM_SHIFT = 2'b10} usm_state_e;
endpackage : usm_pkg

// ### hw/usm_spi_master.sv
/*
 * Master-only SPI engine with APB register access, double-buffered
 * transmitter, two-entry receive queue and three interrupt requests.
 * Assumes pclk at 25 MHz, an APB master on the same clock, and a slave
 * whose data line is asynchronous to pclk (it is synchronised here).
 */
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
module usm_spi_master
   import usm_pkg::*;
#(
   parameter int DIV_W = USM_DIV_W,
   parameter int RX_DEPTH = USM_RX_DEPTH
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_done_irq_ack,
   output logic rx_done_irq,
   output logic tx_done_irq,
   output logic tx_empty_irq,
   output logic serial_clock_pin,
   output logic serial_out_pin,
   output logic serial_out_oe,
   input wire logic serial_in_pin,
   output logic serial_in_owned
);

   localparam int CW = $clog2(RX_DEPTH + 1);

   ////////////////////////////////////////////////////////////////////////
   // Functions
   ////////////////////////////////////////////////////////////////////////

   // Mode field decode, used by engine and by checks
   function automatic logic mode_is_spi(input logic [1:0] m);
      mode_is_spi = (m == USM_MODE_MSPI);
   endfunction : mode_is_spi

   function automatic logic addr_mapped(input logic [11:0] a);
      addr_mapped = (a == USM_OFS_DATA) || (a == USM_OFS_STATUS) || (a == USM_OFS_ENABLE) ||
         (a == USM_OFS_FORMAT) || (a == USM_OFS_DIVISOR) || (a == USM_OFS_CPU);
   endfunction : addr_mapped

   ////////////////////////////////////////////////////////////////////////
   // State
   ////////////////////////////////////////////////////////////////////////

   logic [7:0] en_reg;
   logic [7:0] fmt_reg;
   logic [DIV_W-1:0] div_reg;
   logic gie_reg;
   logic txc_reg;
   logic [7:0] txbuf_reg;
   logic txbuf_valid_reg;
   logic [7:0] tsh_reg;
   logic [7:0] rsh_reg;
   logic [3:0] edge_reg;
   logic [DIV_W-1:0] cnt_reg;
   usm_state_e st_reg;
   logic [7:0] rxq_reg [RX_DEPTH];
   logic [CW-1:0] rxcnt_reg;
   logic own_tx_reg;
   logic miso_s1_reg;
   logic miso_s2_reg;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   ////////////////////////////////////////////////////////////////////////

   // Access phase qualifies every side effect
   wire setup_ph = psel & ~penable;
   wire acc_ph = psel & penable;
   wire wr = acc_ph & pwrite & pstrb[0];
   wire rd = acc_ph & ~pwrite;
   wire hit_data = (paddr == USM_OFS_DATA);
   wire hit_status = (paddr == USM_OFS_STATUS);
   wire hit_enable = (paddr == USM_OFS_ENABLE);
   wire hit_format = (paddr == USM_OFS_FORMAT);
   wire hit_div = (paddr == USM_OFS_DIVISOR);
   wire hit_cpu = (paddr == USM_OFS_CPU);

   // Flags and control fields
   wire rxen = en_reg[USM_EN_RXEN];
   wire txen = en_reg[USM_EN_TXEN];
   wire lsb_first = fmt_reg[USM_FMT_ORDER];
   wire cpha = fmt_reg[USM_FMT_PHASE];
   wire cpol = fmt_reg[USM_FMT_POL];
   wire spi_on = mode_is_spi(fmt_reg[USM_FMT_MODE_LO+1:USM_FMT_MODE_LO]);
   wire rxc = (rxcnt_reg != '0);
   wire udre = ~txbuf_valid_reg;
   wire busy = (st_reg == USM_SHIFT);

   // Status image; low bits fixed at the reset pattern 5'h06
   wire [7:0] status_rd = {rxc, txc_reg, udre, USM_STATUS_LOW};

   // Read mux, captured in the setup phase
   wire [31:0] rd_word = hit_data ? {24'h00_0000, rxq_reg[0]} :
      hit_status ? {24'h00_0000, status_rd} :
      hit_enable ? {24'h00_0000, en_reg} :
      hit_format ? {24'h00_0000, fmt_reg} :
      hit_div ? {{(32-DIV_W){1'b0}}, div_reg} :
      hit_cpu ? {31'h0000_0000, gie_reg} : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // Engine decode
   ////////////////////////////////////////////////////////////////////////

   // Half-period tick; each tick is one serial clock edge
   wire half_tick = busy & (cnt_reg == '0);
   wire last_edge = half_tick & (edge_reg == USM_LAST_EDGE);
   // Even edges lead; phase zero samples there
   wire sample_edge = half_tick & (edge_reg[0] == cpha);
   // Edge zero in phase one only presents the bit already set up
   wire setup_edge = half_tick & (edge_reg[0] != cpha) & (edge_reg != 4'h0);
   // Start needs the transmitter, which owns the clock
   wire tx_allowed = txen | own_tx_reg;
   wire load = spi_on & txbuf_valid_reg & tx_allowed & (~busy | last_edge);
   wire tx_write = wr & hit_data & ~txbuf_valid_reg;
   wire pop = rd & hit_data & rxc;
   wire push = last_edge & rxen;
   wire push_ok = push & (pop | (rxcnt_reg < CW'(RX_DEPTH)));
   wire [CW-1:0] wr_idx = pop ? rxcnt_reg - CW'(1) : rxcnt_reg;

   // Shift datapaths in the chosen order
   wire [7:0] tsh_shift = lsb_first ? {1'b0, tsh_reg[7:1]} : {tsh_reg[6:0], 1'b0};
   wire tx_next_bit = lsb_first ? tsh_reg[1] : tsh_reg[6];
   wire tx_first_bit = lsb_first ? txbuf_reg[0] : txbuf_reg[USM_FRAME_BITS-1];
   wire [7:0] rsh_shift = lsb_first ? {miso_s2_reg, rsh_reg[7:1]} : {rsh_reg[6:0], miso_s2_reg};
   // In phase one the final sample of a frame lands in the same cycle as the push
   wire [7:0] rx_word = sample_edge ? rsh_shift : rsh_reg;

   wire txc_set = last_edge & ~txbuf_valid_reg;
   wire txc_clr = (wr & hit_status & pwdata[USM_ST_TXC]) | tx_done_irq_ack;

   ////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait, error on unmapped address
   ////////////////////////////////////////////////////////////////////////

   // Answer prepared in setup so every bus output is a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         prdata <= setup_ph ? rd_word : prdata;
         pready <= setup_ph;
         pslverr <= setup_ph & ~addr_mapped(paddr);
      end
   end

   // Control registers; mode and format land in one write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_reg <= USM_ENABLE_RST;
         fmt_reg <= USM_FORMAT_RST;
         div_reg <= '0;
         gie_reg <= 1'b0;
      end else if (clk_en && wr) begin
         if (hit_enable) en_reg <= pwdata[7:0];
         if (hit_format) fmt_reg <= pwdata[7:0];
         if (hit_div) div_reg <= pwdata[DIV_W-1:0];
         if (hit_cpu) gie_reg <= pwdata[USM_CPU_GIE];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit side
   ////////////////////////////////////////////////////////////////////////

   // Holding buffer ahead of the shifter; writes to a full buffer are dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txbuf_reg <= 8'h00;
         txbuf_valid_reg <= 1'b0;
      end else if (clk_en) begin
         if (tx_write) begin
            txbuf_reg <= pwdata[7:0];
            txbuf_valid_reg <= 1'b1;
         end else if (load) begin
            txbuf_valid_reg <= 1'b0;
         end
      end
   end

   // Done flag: a set in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) txc_reg <= 1'b0;
      else if (clk_en) txc_reg <= txc_set | (txc_reg & ~txc_clr);
   end

   // Pin stays ours until pending bytes have drained
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) own_tx_reg <= 1'b0;
      else if (clk_en) own_tx_reg <= txen | (own_tx_reg & (busy | txbuf_valid_reg));
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial engine
   ////////////////////////////////////////////////////////////////////////

   // Frame sequencer; leaving SPI mode aborts a frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= USM_IDLE;
         cnt_reg <= '0;
         edge_reg <= 4'h0;
      end else if (clk_en) begin
         case (st_reg)
            USM_IDLE: begin
               if (load) begin
                  st_reg <= USM_SHIFT;
                  cnt_reg <= div_reg;
                  edge_reg <= 4'h0;
               end
            end
            USM_SHIFT: begin
               if (!spi_on) begin
                  st_reg <= USM_IDLE;
               end else if (load) begin
                  cnt_reg <= div_reg;
                  edge_reg <= 4'h0;
               end else if (last_edge) begin
                  st_reg <= USM_IDLE;
               end else if (half_tick) begin
                  cnt_reg <= div_reg;
                  edge_reg <= edge_reg + 4'h1;
               end else begin
                  cnt_reg <= cnt_reg - DIV_W'(1);
               end
            end
            default: st_reg <= USM_IDLE;
         endcase
      end
   end

   // Clock and data out; both rest at idle levels between frames
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_clock_pin <= 1'b0;
         serial_out_pin <= 1'b1;
         tsh_reg <= 8'h00;
      end else if (clk_en) begin
         if (!busy || !spi_on) serial_clock_pin <= cpol;
         else if (half_tick) serial_clock_pin <= ~serial_clock_pin;
         if (load) begin
            tsh_reg <= txbuf_reg;
            serial_out_pin <= tx_first_bit;
         end else if (setup_edge) begin
            tsh_reg <= tsh_shift;
            serial_out_pin <= tx_next_bit;
         end else if (!busy) begin
            serial_out_pin <= 1'b1;
         end
      end
   end

   // Input synchroniser; only the second stage feeds the sampler
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         miso_s1_reg <= 1'b0;
         miso_s2_reg <= 1'b0;
         rsh_reg <= 8'h00;
      end else if (clk_en) begin
         miso_s1_reg <= serial_in_pin;
         miso_s2_reg <= miso_s1_reg;
         if (sample_edge) rsh_reg <= rsh_shift;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive queue
   ////////////////////////////////////////////////////////////////////////

   // Count; disabling the receiver flushes everything
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rxcnt_reg <= '0;
      else if (clk_en) begin
         if (!rxen) rxcnt_reg <= '0;
         else if (push_ok && !pop) rxcnt_reg <= rxcnt_reg + CW'(1);
         else if (pop && !push_ok) rxcnt_reg <= rxcnt_reg - CW'(1);
      end
   end

   // Entries slide toward the head on each read
   genvar gi;
   generate
      for (gi = 0; gi < RX_DEPTH; gi++) begin : g_rxq
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) rxq_reg[gi] <= 8'h00;
            else if (clk_en) begin
               if (push_ok && wr_idx == CW'(gi)) rxq_reg[gi] <= rx_word;
               else if (pop && gi + 1 < RX_DEPTH) rxq_reg[gi] <= rxq_reg[(gi + 1) % RX_DEPTH];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Interrupt requests and pin ownership
   ////////////////////////////////////////////////////////////////////////

   // Registered requests lag the flags by one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_done_irq <= 1'b0;
         tx_done_irq <= 1'b0;
         tx_empty_irq <= 1'b0;
         serial_out_oe <= 1'b0;
         serial_in_owned <= 1'b0;
      end else if (clk_en) begin
         rx_done_irq <= en_reg[USM_EN_RXIE] & gie_reg & rxc;
         tx_done_irq <= en_reg[USM_EN_TXIE] & gie_reg & txc_reg;
         tx_empty_irq <= en_reg[USM_EN_EMPTYIE] & gie_reg & udre;
         serial_out_oe <= own_tx_reg;
         serial_in_owned <= rxen;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   ////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_rx_flush;
      (clk_en && !rxen) |=> (rxcnt_reg == '0);
   endproperty
   a_rx_flush: assert property (p_rx_flush) else $error("receive queue not flushed");

   property p_txc_set;
      (clk_en && last_edge && !txbuf_valid_reg) |=> txc_reg;
   endproperty
   a_txc_set: assert property (p_txc_set) else $error("transmit done flag not set");

   property p_start;
      (clk_en && spi_on && !busy && txbuf_valid_reg && txen) |=> (busy && udre);
   endproperty
   a_start: assert property (p_start) else $error("pending byte not started");

   property p_rx_irq;
      $rose(rx_done_irq) |-> $past(en_reg[USM_EN_RXIE] && gie_reg && rxc);
   endproperty
   a_rx_irq: assert property (p_rx_irq) else $error("receive interrupt without cause");

   property p_tx_irq;
      $rose(tx_done_irq) |-> $past(en_reg[USM_EN_TXIE] && gie_reg && txc_reg);
   endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("transmit interrupt without cause");

   property p_empty_irq;
      $rose(tx_empty_irq) |-> $past(en_reg[USM_EN_EMPTYIE] && gie_reg && udre);
   endproperty
   a_empty_irq: assert property (p_empty_irq) else $error("empty interrupt without cause");

   property p_rx_only;
      (clk_en && !txen && !own_tx_reg && !busy) |=> !busy;
   endproperty
   a_rx_only: assert property (p_rx_only) else $error("transfer started without transmitter");

   property p_drain;
      (clk_en && own_tx_reg && (busy || txbuf_valid_reg)) |=> own_tx_reg ##1 serial_out_oe;
   endproperty
   a_drain: assert property (p_drain) else $error("output pin released too early");

   property p_idle_clk;
      (clk_en && !busy) |=> (serial_clock_pin == $past(cpol));
   endproperty
   a_idle_clk: assert property (p_idle_clk) else $error("clock not at idle level");

   property p_lsb_out;
      (clk_en && setup_edge && !load && lsb_first) |=> (serial_out_pin == $past(tsh_reg[1]));
   endproperty
   a_lsb_out: assert property (p_lsb_out) else $error("wrong bit order on output");

   property p_drop_new;
      (clk_en && push && !pop && rxcnt_reg == CW'(RX_DEPTH)) |=> (rxq_reg[0] == $past(rxq_reg[0]));
   endproperty
   a_drop_new: assert property (p_drop_new) else $error("oldest byte overwritten");

   c_back_to_back: cover property (clk_en && last_edge && load);
   c_overflow: cover property (clk_en && push && !push_ok);
   c_txc_irq: cover property ($rose(tx_done_irq));
   c_lsb_phase1: cover property (clk_en && load && lsb_first && cpha);

endmodule : usm_spi_master

// ### dv/usm_spi_slave_model.sv
/*
 * SPI slave stand-in on the far side of the link.
 * Assumes the bench pulses restart after each format change; the n-th
 * byte sent back after a restart is BASE plus n, with n counted from zero.
 */
`timescale 1ns/100ps
module usm_spi_slave_model #(
   parameter logic [7:0] BASE = 8'h3C
) (
   input wire logic sclk,
   input wire logic mosi,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic lsb_first,
   input wire logic restart,
   output logic miso,
   output logic [7:0] rx_byte,
   output int frame_cnt
);
   logic [7:0] sh;
   logic [7:0] cur;
   int idx;
   ////////////////////////////////////////////////////////////
   // Wire position of the i-th bit
   function automatic int pos(input int i);
      return lsb_first ? i : 7 - i;
   endfunction : pos
   // Sample on the edge picked by phase and polarity, then set up next bit
   always @(sclk or posedge restart) begin
      if (restart) begin
         idx = 0;
         frame_cnt = 0;
      end else if (sclk === ~(cpol ^ cpha)) begin
         sh[pos(idx)] = mosi;
         idx = idx + 1;
         if (idx == 8) begin
            rx_byte = sh;
            frame_cnt = frame_cnt + 1;
            idx = 0;
         end
      end
      // Changing byte per frame makes a dropped byte visible
      cur = BASE + 8'(frame_cnt);
      miso = cur[pos(idx)];
   end
endmodule : usm_spi_slave_model

// ### dv/usart_master_spi_mode_tb_top.sv
/*
 * Self-checking bench of the master SPI engine: APB tasks, a slave model
 * on the link and directed tests.
 * Assumes an APB slave on pclk; divisor 3 gives a 320 ns link clock.
 */
`timescale 1ns/100ps
module usart_master_spi_mode_tb_top
   import usm_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, ack, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic rx_irq, tx_irq, em_irq, sck, mosi, oe, miso, owned;
   logic cpol, cpha, lsb, restart;
   logic [7:0] rxb;
   int frames, errors, cmp_count, cyc;
   ////////////////////////////////////////////////////////////
   usm_spi_master u_dut (
      .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_done_irq_ack(ack), .rx_done_irq(rx_irq),
      .tx_done_irq(tx_irq), .tx_empty_irq(em_irq), .serial_clock_pin(sck),
      .serial_out_pin(mosi), .serial_out_oe(oe), .serial_in_pin(miso), .serial_in_owned(owned)
   );
   usm_spi_slave_model u_slave (
      .sclk(sck), .mosi(mosi), .cpol(cpol), .cpha(cpha), .lsb_first(lsb),
      .restart(restart), .miso(miso), .rx_byte(rxb), .frame_cnt(frames)
   );
   // Clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // Hang guard, well above the fewer than two thousand cycles the tests need
   initial begin
      cyc = 0;
      forever begin
         @(posedge pclk);
         cyc++;
         if (cyc == 20000) begin
            errors++;
            conclude();
         end
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // One APB transfer; entered just after a rising edge
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No timeout here; if pready never comes, only the hang guard ends this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask : wr
   task automatic rd(input logic [11:0] a);
      xfer(a, 1'b0, 32'h0000_0000);
   endtask : rd
   // Registered outputs lag their cause; let two edges land
   task automatic settle();
      repeat (2) @(posedge pclk);
   endtask : settle
   task automatic pulse();
      restart <= 1'b1;
      @(posedge pclk);
      restart <= 1'b0;
   endtask : pulse
   // Poll the status until the transmit-done flag shows
   task automatic wait_done();
      do begin
         rd(USM_OFS_STATUS);
      end while (q[USM_ST_TXC] !== 1'b1);
   endtask : wait_done
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////
   // Directed tests
   initial begin
      {psel, penable, pwrite, ack, presetn, restart, cpol, cpha, lsb} = 9'h000;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      errors = 0;
      cmp_count = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(USM_OFS_STATUS);
      check(q, 32'h0000_0026);
      check(32'({oe, owned, sck}), 32'h0000_0000);
      rd(12'h020);
      check(32'({e, q[0]}), 32'h0000_0002);
      $display("reset test done");
      wr(USM_OFS_DIVISOR, 32'h0000_0003);
      wr(USM_OFS_CPU, 32'h0000_0001);
      wr(USM_OFS_ENABLE, 32'h0000_0018);
      settle();
      check(32'({oe, owned}), 32'h0000_0003);
      // Every polarity, phase and order
      for (int m = 0; m < 8; m++) begin
         {lsb, cpha, cpol} <= 3'(m);
         wr(USM_OFS_FORMAT, 32'h0000_00C0 + 32'(m));
         rd(USM_OFS_FORMAT);
         check(q, 32'h0000_00C0 + 32'(m));
         pulse();
         check(32'(sck), 32'(cpol));
         wr(USM_OFS_DATA, 32'h0000_00B1 + 32'(m));
         wait_done();
         check(32'(rxb), 32'h0000_00B1 + 32'(m));
         check(32'(frames), 32'h0000_0001);
         check(32'(sck), 32'(cpol));
         rd(USM_OFS_DATA);
         check(q, 32'h0000_003C);
         rd(USM_OFS_STATUS);
         check(q, 32'h0000_0066);
         wr(USM_OFS_STATUS, 32'h0000_0040);
         rd(USM_OFS_STATUS);
         check(q, 32'h0000_0026);
      end
      $display("mode test done");
      pulse();
      wr(USM_OFS_DATA, 32'h0000_0011);
      wr(USM_OFS_DATA, 32'h0000_0022);
      rd(USM_OFS_STATUS);
      check(q & 32'h0000_0020, 32'h0000_0000);
      wait_done();
      check(32'({frames[7:0], rxb}), 32'h0000_0222);
      wr(USM_OFS_STATUS, 32'h0000_0040);
      wr(USM_OFS_DATA, 32'h0000_0033);
      wait_done();
      rd(USM_OFS_DATA);
      check(q, 32'h0000_003C);
      rd(USM_OFS_DATA);
      check(q, 32'h0000_003D);
      rd(USM_OFS_STATUS);
      check(q, 32'h0000_0066);
      $display("buffer test done");
      wr(USM_OFS_ENABLE, 32'h0000_00F8);
      settle();
      check(32'({rx_irq, tx_irq, em_irq}), 32'h0000_0003);
      ack <= 1'b1;
      @(posedge pclk);
      ack <= 1'b0;
      rd(USM_OFS_STATUS);
      check(q, 32'h0000_0026);
      wr(USM_OFS_DATA, 32'h0000_0066);
      wait_done();
      settle();
      check(32'({rx_irq, tx_irq, em_irq}), 32'h0000_0007);
      wr(USM_OFS_CPU, 32'h0000_0000);
      settle();
      check(32'({rx_irq, tx_irq, em_irq}), 32'h0000_0000);
      wr(USM_OFS_CPU, 32'h0000_0001);
      wr(USM_OFS_ENABLE, 32'h0000_0008);
      settle();
      check(32'({owned, rx_irq}), 32'h0000_0000);
      rd(USM_OFS_STATUS);
      check(q, 32'h0000_0066);
      wr(USM_OFS_STATUS, 32'h0000_0040);
      $display("interrupt test done");
      wr(USM_OFS_ENABLE, 32'h0000_0010);
      wr(USM_OFS_DATA, 32'h0000_0044);
      repeat (100) @(posedge pclk);
      check(32'({frames[7:0], 7'h00, sck}), 32'h0000_0401);
      // Pending byte must stay put in every non-SPI mode
      for (int md = 0; md < 3; md++) begin
         wr(USM_OFS_FORMAT, 32'h0000_0007 + 32'(md * 64));
         wr(USM_OFS_ENABLE, 32'h0000_0018);
         repeat (100) @(posedge pclk);
         check(32'(frames), 32'h0000_0004);
      end
      wr(USM_OFS_FORMAT, 32'h0000_00C7);
      wr(USM_OFS_DATA, 32'h0000_0055);
      wr(USM_OFS_ENABLE, 32'h0000_0010);
      settle();
      check(32'(oe), 32'h0000_0001);
      wait_done();
      settle();
      check(32'({frames[7:0], rxb, 7'h00, oe}), 32'h0006_5500);
      $display("enable test done");
      conclude();
   end
endmodule : usart_master_spi_mode_tb_top
